// ===== verilog/rfc_top.sv
// reciprocal counting gate core with axi4-lite registers
`timescale 1ns/1ps
module rfc_top #(
    parameter int MS_CYCLES = rfc_pkg::MS_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [rfc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [rfc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // comparator side
    input wire logic trig_in,
    input wire logic level_ok,
    // status outputs
    output logic gate_out,
    output logic irq
);
    // bus slave state
    logic aw_hold_reg, aw_hold_next;
    logic [5:0] aw_addr_reg, aw_addr_next;
    logic w_hold_reg, w_hold_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_go, wr_ok;
    // configuration and interrupt state
    logic run_reg, run_next, start;
    rfc_pkg::rfc_func_t func_reg, func_next;
    logic [31:0] meas_reg, meas_next;
    logic tmo_en_reg, tmo_en_next;
    logic [19:0] tmo_ms_reg, tmo_ms_next;
    logic [15:0] lf_reg, lf_next;
    logic [1:0] ists_reg, ists_next, ien_reg, ien_next, ev;
    logic irq_reg, irq_next;
    // measurement state
    rfc_pkg::rfc_state_t st_reg, st_next;
    logic [31:0] mt_reg, mt_next, cnt_reg, cnt_next;
    logic [63:0] dur_reg, dur_next;
    logic [7:0] psc_reg, psc_next;
    logic [31:0] msd_reg, msd_next;
    logic [19:0] tmc_reg, tmc_next;
    logic [31:0] rcnt_reg, rcnt_next;
    logic [63:0] rdur_reg, rdur_next;
    logic [8:0] rfac_reg, rfac_next;
    logic absent_reg, absent_next, gate_reg, gate_next;
    // derived terms
    logic [8:0] fac;
    logic tq, evt, ms_tick, single, mt_done, tmo_exp, abort, done;

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // division factor of the selected function
    always_comb begin
        case (func_reg)
            rfc_pkg::FN_FREQ: fac = rfc_pkg::FAC_2;
            rfc_pkg::FN_BHI: fac = rfc_pkg::FAC_2;
            rfc_pkg::FN_PAVG: fac = rfc_pkg::FAC_2;
            rfc_pkg::FN_C3: fac = rfc_pkg::FAC_16;
            rfc_pkg::FN_C8: fac = rfc_pkg::FAC_256;
            rfc_pkg::FN_C20: fac = rfc_pkg::FAC_128;
            default: fac = rfc_pkg::FAC_1;
        endcase
    end

    // trigger qualification and prescaled event
    assign tq = trig_in & level_ok;
    assign evt = tq && ({1'b0, psc_reg} == (fac - rfc_pkg::FAC_1));
    assign ms_tick = (msd_reg == 32'(MS_CYCLES - 1));
    assign single = (func_reg == rfc_pkg::FN_PSGL);
    assign mt_done = (mt_reg >= meas_reg);
    // no trigger for the whole interval ends the measurement
    assign tmo_exp = tmo_en_reg && (st_reg != rfc_pkg::ST_IDLE)
                     && (tmc_reg >= tmo_ms_reg);
    // signal gone mid-measurement aborts without touching results
    assign abort = tmo_exp || ((st_reg != rfc_pkg::ST_IDLE) && !level_ok);
    assign done = (st_reg == rfc_pkg::ST_OPEN) && evt && !abort
                  && (single || mt_done);
    assign ev = {tmo_exp, done};

    // bus writes land only when address and data are both held
    assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_ok = (aw_addr_reg[5:2] == rfc_pkg::OFF_CTRL[5:2])
                   || (aw_addr_reg[5:2] == rfc_pkg::OFF_MEAS[5:2])
                   || (aw_addr_reg[5:2] == rfc_pkg::OFF_TMO[5:2])
                   || (aw_addr_reg[5:2] == rfc_pkg::OFF_LF[5:2])
                   || (aw_addr_reg[5:2] == rfc_pkg::OFF_ICLR[5:2])
                   || (aw_addr_reg[5:2] == rfc_pkg::OFF_IEN[5:2]);

    // bus channel next state and read mux
    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        // address and data are taken in either order
        if (s_axi_awvalid && awready_reg) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_go) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_ok ? rfc_pkg::RESP_OKAY : rfc_pkg::RESP_SLVERR;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = rfc_pkg::RESP_OKAY;
            case (s_axi_araddr[5:2])
                rfc_pkg::OFF_CTRL[5:2]: rdata_next = {25'h0, func_reg, 3'h0, run_reg};
                rfc_pkg::OFF_MEAS[5:2]: rdata_next = meas_reg;
                rfc_pkg::OFF_TMO[5:2]: rdata_next = {tmo_en_reg, 11'h0, tmo_ms_reg};
                rfc_pkg::OFF_LF[5:2]: rdata_next = {16'h0, lf_reg};
                rfc_pkg::OFF_RCNT[5:2]: rdata_next = rcnt_reg;
                rfc_pkg::OFF_RDLO[5:2]: rdata_next = rdur_reg[31:0];
                rfc_pkg::OFF_RDHI[5:2]: rdata_next = rdur_reg[63:32];
                rfc_pkg::OFF_RFAC[5:2]: rdata_next = {23'h0, rfac_reg};
                rfc_pkg::OFF_STAT[5:2]: rdata_next = {27'h0, st_reg, absent_reg,
                                                      gate_reg, run_reg};
                rfc_pkg::OFF_ISTS[5:2]: rdata_next = {30'h0, ists_reg};
                rfc_pkg::OFF_ICLR[5:2]: rdata_next = 32'h0;
                rfc_pkg::OFF_IEN[5:2]: rdata_next = {30'h0, ien_reg};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = rfc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // ready stays low while a beat is held or an answer waits
        awready_next = !aw_hold_next && !bvalid_next;
        wready_next = !w_hold_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    // bus channel registers
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 6'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            arready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= rfc_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= rfc_pkg::RESP_OKAY;
            rdata_reg <= 32'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // configuration and interrupt next state
    always_comb begin
        logic [31:0] m;
        m = 32'h0;
        run_next = run_reg;
        func_next = func_reg;
        meas_next = meas_reg;
        tmo_en_next = tmo_en_reg;
        tmo_ms_next = tmo_ms_reg;
        lf_next = lf_reg;
        ien_next = ien_reg;
        ists_next = ists_reg;
        start = 1'b0;
        if (wr_go) begin
            case (aw_addr_reg[5:2])
                rfc_pkg::OFF_CTRL[5:2]: begin
                    m = merge({25'h0, func_reg, 3'h0, run_reg}, w_data_reg, w_strb_reg);
                    run_next = m[rfc_pkg::CTRL_RUN];
                    start = m[rfc_pkg::CTRL_START];
                    func_next = rfc_pkg::rfc_func_t'(m[rfc_pkg::CTRL_FUNC +: 3]);
                end
                rfc_pkg::OFF_MEAS[5:2]: begin
                    meas_next = merge(meas_reg, w_data_reg, w_strb_reg);
                end
                rfc_pkg::OFF_TMO[5:2]: begin
                    m = merge({tmo_en_reg, 11'h0, tmo_ms_reg}, w_data_reg, w_strb_reg);
                    tmo_en_next = m[rfc_pkg::TMO_EN];
                    // clamp into the 10 ms to 1000 s range
                    if (m[19:0] < rfc_pkg::TMO_MS_MIN) begin
                        tmo_ms_next = rfc_pkg::TMO_MS_MIN;
                    end else if (m[19:0] > rfc_pkg::TMO_MS_MAX) begin
                        tmo_ms_next = rfc_pkg::TMO_MS_MAX;
                    end else begin
                        tmo_ms_next = m[19:0];
                    end
                end
                rfc_pkg::OFF_LF[5:2]: begin
                    m = merge({16'h0, lf_reg}, w_data_reg, w_strb_reg);
                    // 0 Hz makes no sense, floor at 1 Hz
                    lf_next = (m[15:0] < rfc_pkg::LF_MIN) ? rfc_pkg::LF_MIN : m[15:0];
                end
                rfc_pkg::OFF_ICLR[5:2]: begin
                    ists_next = ists_reg & ~w_data_reg[1:0];
                end
                rfc_pkg::OFF_IEN[5:2]: begin
                    ien_next = w_strb_reg[0] ? w_data_reg[1:0] : ien_reg;
                end
                default: begin
                    m = 32'h0;
                end
            endcase
        end
        // a new event outranks a clear in the same cycle
        ists_next = ists_next | ev;
        irq_next = |(ists_next & ien_next);
    end

    // configuration and interrupt registers
    always_ff @(posedge clk) begin
        if (rst) begin
            run_reg <= 1'b0;
            func_reg <= rfc_pkg::FN_FREQ;
            meas_reg <= rfc_pkg::MEAS_RST;
            tmo_en_reg <= 1'b0;
            tmo_ms_reg <= rfc_pkg::TMO_MS_RST;
            lf_reg <= rfc_pkg::LF_RST;
            ien_reg <= 2'h0;
            ists_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            func_reg <= func_next;
            meas_reg <= meas_next;
            tmo_en_reg <= tmo_en_next;
            tmo_ms_reg <= tmo_ms_next;
            lf_reg <= lf_next;
            ien_reg <= ien_next;
            ists_reg <= ists_next;
            irq_reg <= irq_next;
        end
    end

    // gate sequencer and counters, next state
    always_comb begin
        st_next = st_reg;
        mt_next = (&mt_reg) ? mt_reg : mt_reg + 32'h1;
        cnt_next = cnt_reg;
        dur_next = dur_reg;
        rcnt_next = rcnt_reg;
        rdur_next = rdur_reg;
        rfac_next = rfac_reg;
        absent_next = absent_reg;
        msd_next = ms_tick ? 32'h0 : msd_reg + 32'h1;
        psc_next = psc_reg;
        // prescaler divides qualified triggers; cleared while idle
        if (st_reg == rfc_pkg::ST_IDLE) begin
            psc_next = 8'h00;
        end else if (tq) begin
            psc_next = evt ? 8'h00 : psc_reg + 8'h01;
        end
        // time-out counts ms since the last trigger
        if (tq || st_reg == rfc_pkg::ST_IDLE) begin
            tmc_next = 20'h0;
        end else if (ms_tick && !(&tmc_reg)) begin
            tmc_next = tmc_reg + 20'h1;
        end else begin
            tmc_next = tmc_reg;
        end
        case (st_reg)
            rfc_pkg::ST_IDLE: begin
                // a trigger in the starting cycle is not looked at
                if (run_reg || start) begin
                    st_next = rfc_pkg::ST_ARM;
                    mt_next = 32'h0;
                end
            end
            rfc_pkg::ST_ARM: begin
                if (abort) begin
                    st_next = rfc_pkg::ST_IDLE;
                    absent_next = tmo_exp ? 1'b1 : absent_reg;
                end else if (evt) begin
                    st_next = rfc_pkg::ST_OPEN;
                    cnt_next = 32'h0;
                    dur_next = 64'h0;
                end
            end
            rfc_pkg::ST_OPEN: begin
                // both counters run together while the gate is open
                dur_next = dur_reg + 64'(rfc_pkg::DUR_STEP);
                cnt_next = evt ? cnt_reg + 32'h1 : cnt_reg;
                if (abort) begin
                    st_next = rfc_pkg::ST_IDLE;
                    absent_next = tmo_exp ? 1'b1 : absent_reg;
                end else if (done) begin
                    // one consistent result set per gate
                    rcnt_next = cnt_reg + 32'h1;
                    rdur_next = dur_reg + 64'(rfc_pkg::DUR_STEP);
                    rfac_next = fac;
                    absent_next = 1'b0;
                    st_next = run_reg ? rfc_pkg::ST_ARM : rfc_pkg::ST_IDLE;
                    mt_next = 32'h0;
                end
            end
            default: begin
                st_next = rfc_pkg::ST_IDLE;
            end
        endcase
        gate_next = (st_next == rfc_pkg::ST_OPEN);
    end

    // gate sequencer and counter registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= rfc_pkg::ST_IDLE;
            mt_reg <= 32'h0;
            cnt_reg <= 32'h0;
            dur_reg <= 64'h0;
            rcnt_reg <= 32'h0;
            rdur_reg <= 64'h0;
            rfac_reg <= rfc_pkg::FAC_1;
            absent_reg <= 1'b0;
            msd_reg <= 32'h0;
            psc_reg <= 8'h00;
            tmc_reg <= 20'h0;
            gate_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            mt_reg <= mt_next;
            cnt_reg <= cnt_next;
            dur_reg <= dur_next;
            rcnt_reg <= rcnt_next;
            rdur_reg <= rdur_next;
            rfac_reg <= rfac_next;
            absent_reg <= absent_next;
            msd_reg <= msd_next;
            psc_reg <= psc_next;
            tmc_reg <= tmc_next;
            gate_reg <= gate_next;
        end
    end

    // outputs
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign gate_out = gate_reg;
    assign irq = irq_reg;

    // checks
    open_on_evt_a: assert property (@(posedge clk) disable iff (rst)
        (st_reg == rfc_pkg::ST_ARM && !evt) |=> st_reg != rfc_pkg::ST_OPEN)
        else $error("gate opened without a trigger");
    close_on_evt_a: assert property (@(posedge clk) disable iff (rst)
        (st_reg == rfc_pkg::ST_OPEN && !evt && !abort) |=> st_reg == rfc_pkg::ST_OPEN)
        else $error("gate closed between triggers");
    dur_step_a: assert property (@(posedge clk) disable iff (rst)
        (st_reg == rfc_pkg::ST_OPEN ##1 st_reg == rfc_pkg::ST_OPEN)
        |-> dur_reg == $past(dur_reg) + 64'(rfc_pkg::DUR_STEP))
        else $error("duration step wrong");
    latch_set_a: assert property (@(posedge clk) disable iff (rst)
        done |=> rcnt_reg == $past(cnt_reg) + 32'h1 && rfac_reg == $past(fac))
        else $error("result set not latched together");
    c8_factor_a: assert property (@(posedge clk) disable iff (rst)
        (func_reg == rfc_pkg::FN_C8) |-> fac == rfc_pkg::FAC_256)
        else $error("wrong factor for high input");
    tmo_flag_a: assert property (@(posedge clk) disable iff (rst)
        tmo_exp |=> absent_reg && st_reg == rfc_pkg::ST_IDLE)
        else $error("time-out not flagged");
    hold_result_a: assert property (@(posedge clk) disable iff (rst)
        abort |=> $stable(rcnt_reg) && $stable(rdur_reg))
        else $error("result changed on lost signal");
    single_close_a: assert property (@(posedge clk) disable iff (rst)
        (st_reg == rfc_pkg::ST_OPEN && single && evt && !abort)
        |=> st_reg != rfc_pkg::ST_OPEN)
        else $error("single gate overran one cycle");
    // the prescaler must not even advance while the level is missing
    presc_block_a: assert property (@(posedge clk) disable iff (rst)
        !level_ok |-> !evt ##1 ($stable(psc_reg) || $past(st_reg) == rfc_pkg::ST_IDLE))
        else $error("prescaler output not blocked");
    tmo_restart_a: assert property (@(posedge clk) disable iff (rst)
        tq |=> tmc_reg == 20'h0)
        else $error("time-out not restarted");
endmodule

// ===== verilog/rfc_pkg.sv
// constants, types and register map of the reciprocal frequency counter core
package rfc_pkg;
    // bus geometry
    localparam int ADDR_W = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // register byte offsets
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_MEAS = 6'h04;
    localparam logic [5:0] OFF_TMO = 6'h08;
    localparam logic [5:0] OFF_LF = 6'h0C;
    localparam logic [5:0] OFF_RCNT = 6'h10;
    localparam logic [5:0] OFF_RDLO = 6'h14;
    localparam logic [5:0] OFF_RDHI = 6'h18;
    localparam logic [5:0] OFF_RFAC = 6'h1C;
    localparam logic [5:0] OFF_STAT = 6'h20;
    localparam logic [5:0] OFF_ISTS = 6'h24;
    localparam logic [5:0] OFF_ICLR = 6'h28;
    localparam logic [5:0] OFF_IEN = 6'h2C;
    // field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_FUNC = 4;
    localparam int TMO_EN = 31;
    localparam int INT_DONE = 0;
    localparam int INT_ABSENT = 1;
    // reset values
    localparam logic [31:0] MEAS_RST = 32'h0003_D090;
    localparam logic [19:0] TMO_MS_RST = 20'h0_03E8;
    localparam logic [15:0] LF_RST = 16'h0064;
    // limits
    localparam logic [19:0] TMO_MS_MIN = 20'h0_000A;
    localparam logic [19:0] TMO_MS_MAX = 20'hF_4240;
    localparam logic [15:0] LF_MIN = 16'h0001;
    // timing: 40 ns clock, 100 ps duration unit, 1 ms time-out tick
    localparam int CLK_PS = 40000;
    localparam int RES_PS = 100;
    localparam logic [15:0] DUR_STEP = 16'(CLK_PS / RES_PS);
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 40;
    localparam int MS_CYC = MS_NS / CLK_NS;
    // prescaler division factors
    localparam logic [8:0] FAC_1 = 9'h001;
    localparam logic [8:0] FAC_2 = 9'h002;
    localparam logic [8:0] FAC_16 = 9'h010;
    localparam logic [8:0] FAC_128 = 9'h080;
    localparam logic [8:0] FAC_256 = 9'h100;
    // measuring functions
    typedef enum logic [2:0] {
        FN_FREQ = 3'h0, FN_BLO = 3'h1, FN_BHI = 3'h2, FN_PAVG = 3'h3,
        FN_PSGL = 3'h4, FN_C3 = 3'h5, FN_C8 = 3'h6, FN_C20 = 3'h7
    } rfc_func_t;
    // gate sequencer, gray along idle, arm, open
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0, ST_ARM = 2'h1, ST_OPEN = 2'h3
    } rfc_state_t;
endpackage

// ===== tb/rfc_trig_model.sv
// comparator trigger stream model for the counter core
`timescale 1ns/1ps
module rfc_trig_model (
    // clock
    input wire logic clk,
    // stream control from the bench
    input wire logic en,
    input wire logic [7:0] period,
    input wire logic present,
    // comparator outputs
    output logic trig_in,
    output logic level_ok
);
    logic [7:0] cnt = 8'h00;
    // presence follows the bench; no filtering, so a drop is seen at once
    assign level_ok = present;
    initial trig_in = 1'b0;
    // one-cycle pulse every period cycles, only while the burst lasts
    always @(posedge clk) begin
        cnt <= (cnt >= period - 8'h01) ? 8'h00 : cnt + 8'h01;
        trig_in <= en && (cnt == 8'h00);
    end
endmodule

// ===== tb/tb_rfc_top.sv
// self-checking bench for the reciprocal counter core
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_rfc_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rd_d, keep;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic en = 1'b0, present = 1'b1;
    logic [7:0] per = 8'h03;
    logic [1:0] resp;
    logic [8:0] fac [8];
    wire awready, wready, bvalid, arready, rvalid, trig, lok, gate, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int n_fail = 0, comparisons = 0;
    // short ms tick keeps the 10 ms time-out at 100 cycles
    rfc_top #(.MS_CYCLES(10)) rfc_top_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .trig_in(trig), .level_ok(lok), .gate_out(gate), .irq(irq));
    rfc_trig_model rfc_trig_model_inst (.clk(clk), .en(en), .period(per), .present(present),
        .trig_in(trig), .level_ok(lok));
    initial forever #20 clk = ~clk;
    // axi write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bit pa, pw;
        @(posedge clk);
        pa = 1;
        pw = 1;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awready === 1'b1) begin pa = 0; awvalid <= 1'b0; end
            if (pw && wready === 1'b1) begin pw = 0; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        resp = bresp;
        bready <= 1'b0;
    endtask
    // axi read: rready held until the data is sampled
    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd_d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // clear flags, then launch one measurement
    task automatic go(input logic [31:0] c);
        wr(rfc_pkg::OFF_ICLR, 32'h3);
        wr(rfc_pkg::OFF_CTRL, c);
    endtask
    // poll a status bit; bounded so a stuck core falls through to the checks
    task automatic wait_int(input int b);
        for (int k = 0; k < 1000; k++) begin
            rd(rfc_pkg::OFF_ISTS);
            if (rd_d[b] === 1'b1) break;
        end
    endtask
    task print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        fac = '{rfc_pkg::FAC_2, rfc_pkg::FAC_1, rfc_pkg::FAC_2, rfc_pkg::FAC_2,
            rfc_pkg::FAC_1, rfc_pkg::FAC_16, rfc_pkg::FAC_256, rfc_pkg::FAC_128};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(rfc_pkg::OFF_MEAS);
        `CHK("meas", rfc_pkg::MEAS_RST, rd_d)
        rd(rfc_pkg::OFF_TMO);
        `CHK("tmo", 32'h0000_03E8, rd_d)
        rd(rfc_pkg::OFF_LF);
        `CHK("lf", 32'h0000_0064, rd_d)
        $display("test reset done");
        // every function, shortest time: gate spans one prescaled cycle
        wr(rfc_pkg::OFF_IEN, 32'h3);
        wr(rfc_pkg::OFF_TMO, 32'h8000_000A);
        wr(rfc_pkg::OFF_MEAS, 32'h1);
        en <= 1'b1;
        for (int f = 0; f < 8; f++) begin
            go({25'h0, f[2:0], 4'h2});
            wait_int(0);
            rd(rfc_pkg::OFF_RFAC);
            `CHK("fac", {23'h0, fac[f]}, rd_d)
            rd(rfc_pkg::OFF_RCNT);
            `CHK("rcnt", 32'h1, rd_d)
            rd(rfc_pkg::OFF_RDLO);
            `CHK("rdur", 32'(fac[f]) * 32'd1200, rd_d)
            rd(rfc_pkg::OFF_ISTS);
            `CHK("ists", 32'h1, rd_d)
            `CHK("irq", 1'b1, irq)
        end
        $display("test factors done");
        // longer time: gate closes on the first event after it ends
        wr(rfc_pkg::OFF_MEAS, 32'd20);
        per <= 8'h07;
        go(32'h12);
        // ten cycles into the set time the gate is open and still running
        repeat (10) @(posedge clk);
        `CHK("gate open", 1'b1, gate)
        wait_int(0);
        rd(rfc_pkg::OFF_RCNT);
        keep = rd_d;
        `CHK("rcnt range", 1'b1, rd_d inside {2, 3})
        rd(rfc_pkg::OFF_RDLO);
        `CHK("rdur", keep * 32'd2800, rd_d)
        $display("test gate done");
        // no signal blocks counting; then silence runs into the time-out
        present <= 1'b0;
        go(32'h12);
        repeat (60) @(posedge clk);
        `CHK("gate", 1'b0, gate)
        rd(rfc_pkg::OFF_ISTS);
        `CHK("ists", 32'h0, rd_d)
        present <= 1'b1;
        en <= 1'b0;
        go(32'h12);
        wait_int(1);
        rd(rfc_pkg::OFF_ISTS);
        `CHK("absent", 32'h2, rd_d)
        rd(rfc_pkg::OFF_RCNT);
        `CHK("held", keep, rd_d)
        wr(rfc_pkg::OFF_IEN, 32'h0);
        @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        wr(rfc_pkg::OFF_IEN, 32'h3);
        wr(rfc_pkg::OFF_ICLR, 32'h3);
        @(posedge clk);
        `CHK("irq clr", 1'b0, irq)
        $display("test absent done");
        wr(rfc_pkg::OFF_RCNT, 32'h5);
        `CHK("ro wr", rfc_pkg::RESP_SLVERR, resp)
        rd(6'h30);
        `CHK("bad rd", rfc_pkg::RESP_SLVERR, resp)
        $display("test bus done");
        print_verdict();
    end
endmodule
